//--- hw/irq_expander_consts.vh
// Constants for the interrupt expander bus glue: timing, jumper table and register map
`ifndef IRQ_EXPANDER_CONSTS_VH
`define IRQ_EXPANDER_CONSTS_VH

// Local clock period in ns (200 MHz)
`define CLK_PERIOD_NS 5
// Bus T-state period in ns for the two bus speeds
`define BUS_PERIOD_SLOW_NS 400
`define BUS_PERIOD_FAST_NS 250
// Delay of one interrupt unit through the priority chain, ns
`define UNIT_DELAY_SLOW_NS 260
`define UNIT_DELAY_FAST_NS 200

// Maximum unit counts per jumper setting, slow and fast bus
`define UNITS_BOTH_SLOW 6'h0f
`define UNITS_BOTH_FAST 6'h0e
`define UNITS_UPPER_SLOW 6'h19
`define UNITS_UPPER_FAST 6'h18
`define UNITS_NONE_SLOW 6'h28
`define UNITS_NONE_FAST 6'h22

// Prefix wait states and opcode values
`define PREFIX_WAITS 6'h01
`define OPC_PREFIX 8'hed
`define OPC_RETURN 8'h4d

// Register offsets
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_MASK 2'h2
`define REG_INFO 2'h3

// Control register fields and reset value
`define CTRL_EXP_EN 0
`define CTRL_FAST 1
`define CTRL_RESET 8'h01

// Status register event bits
`define EV_PREFIX 0
`define EV_RETURN 1
`define EV_OTHER 2
`define EV_WIDTH 3

`endif

//--- hw/interrupt_expander_wait_logic.v
// Bus glue for the interrupt and timer expansion board: decode, transceiver, wait sequencer
`timescale 1ns/1ps
//
// Contract
// - Channel select is address bits one and zero.
// - Transceiver drives out on board reads and on vector reads.
// - Prefix byte fetch gets one wait state.
// - Return byte after prefix adds unit-count waits.
// - Expansion disable jumper blocks every wait state.
// - Address bits read one unless jumper fitted.
// - Two jumpers pick fifteen, twenty-five, forty units on slow bus; fourteen, twenty-four, thirty-four on fast.
// - Optional jumper adds one more wait state.
// - Eight-bit ports, four ports, six bits matched.
// - No software-visible effect when timer unused.
// - Bring out zero counts, buffer four triggers.
// - Timer enable on address match with request.
// - Waits only while interrupt pending or serviced.
`include "irq_expander_consts.vh"

module interrupt_expander_wait_logic (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Backplane bus pins
   input wire [7:0] i_addr,
   input wire [7:0] i_data,
   input wire i_iorq_n,
   input wire i_rd_n,
   input wire i_m1_n,
   input wire i_int_active,
   // Board jumpers, high when fitted
   input wire [5:0] i_board_address_header,
   input wire [1:0] i_unit_count_header,
   input wire i_one_more_jumper,
   input wire i_expansion_disable_jumper,
   // Counter/timer connector pins
   input wire [3:0] i_count_trigger_input,
   input wire [2:0] i_zero_count_chip,
   // Bus side outputs
   output reg o_bus_wait_n,
   output wire o_xcvr_drive_out,
   output reg o_counter_timer_chip_enable,
   output reg [1:0] o_channel_select,
   // Connector side outputs
   output reg [3:0] o_count_trigger,
   output reg [2:0] o_zero_count_output,
   // Register port
   input wire [1:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   // Interrupt
   output wire o_irq
);

   localparam SYNC_W = 37;
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_PREFIX = 5'h02;
   localparam [4:0] ST_AWAIT = 5'h04;
   localparam [4:0] ST_NEXT = 5'h08;
   localparam [4:0] ST_STRETCH = 5'h10;
   localparam integer DIV_SLOW_N = (`BUS_PERIOD_SLOW_NS / `CLK_PERIOD_NS) - 1;
   localparam integer DIV_FAST_N = (`BUS_PERIOD_FAST_NS / `CLK_PERIOD_NS) - 1;
   localparam [6:0] DIV_SLOW = DIV_SLOW_N[6:0];
   localparam [6:0] DIV_FAST = DIV_FAST_N[6:0];
   // Strobes reset to their idle high level so nothing looks active after reset
   localparam [SYNC_W-1:0] SYNC_IDLE = 37'h00001c0000;

   // Wait states for a unit count, rounded up so the chain always settles
   function [5:0] waits_for;
      input [5:0] units;
      input fast;
      integer ns;
      integer per;
      integer q;
      begin
         ns = units * (fast ? `UNIT_DELAY_FAST_NS : `UNIT_DELAY_SLOW_NS);
         per = fast ? `BUS_PERIOD_FAST_NS : `BUS_PERIOD_SLOW_NS;
         q = (ns + per - 1) / per;
         waits_for = q[5:0];
      end
   endfunction

   // Two-flop synchronisers for every pin
   reg [SYNC_W-1:0] sync1;
   reg [SYNC_W-1:0] sync2;
   wire [SYNC_W-1:0] pins;
   assign pins = {i_addr, i_data, i_iorq_n, i_rd_n, i_m1_n, i_int_active, i_board_address_header,
      i_unit_count_header, i_one_more_jumper, i_expansion_disable_jumper, i_count_trigger_input,
      i_zero_count_chip};

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= SYNC_IDLE;
         sync2 <= SYNC_IDLE;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   wire [7:0] s_addr = sync2[36:29];
   wire [7:0] s_data = sync2[28:21];
   wire s_iorq = ~sync2[20];
   wire s_rd = ~sync2[19];
   wire s_m1 = ~sync2[18];
   wire s_int = sync2[17];
   wire [5:0] s_addr_jmp = sync2[16:11];
   wire [1:0] s_unit_jmp = sync2[10:9];
   wire s_one_more = sync2[8];
   wire s_exp_jmp = sync2[7];
   wire [3:0] s_trig = sync2[6:3];
   wire [2:0] s_zc = sync2[2:0];

   // Registers
   reg [7:0] ctrl;
   reg [`EV_WIDTH-1:0] status;
   reg [`EV_WIDTH-1:0] mask;
   reg [`EV_WIDTH-1:0] events;

   // Decode of board address and transceiver direction
   wire [5:0] board_addr = ~s_addr_jmp;
   wire addr_match = (s_addr[7:2] == board_addr);
   wire board_io = s_iorq & ~s_m1 & addr_match;
   wire vector_read = s_iorq & s_m1;
   assign o_xcvr_drive_out = (board_io & s_rd) | vector_read;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_counter_timer_chip_enable <= 1'b0;
         o_channel_select <= 2'h0;
         o_count_trigger <= 4'h0;
         o_zero_count_output <= 3'h0;
      end else begin
         o_counter_timer_chip_enable <= s_iorq & addr_match;
         o_channel_select <= s_addr[1:0];
         o_count_trigger <= s_trig;
         o_zero_count_output <= s_zc;
      end
   end

   // Unit count and speed selection
   reg [5:0] units;
   wire fast = ctrl[`CTRL_FAST];
   always @* begin
      case (s_unit_jmp)
         2'b11: units = fast ? `UNITS_BOTH_FAST : `UNITS_BOTH_SLOW;
         2'b10: units = fast ? `UNITS_UPPER_FAST : `UNITS_UPPER_SLOW;
         default: units = fast ? `UNITS_NONE_FAST : `UNITS_NONE_SLOW;
      endcase
   end
   // Fitting the expansion disable jumper disables, software may also disable
   wire exp_enable = ~s_exp_jmp & ctrl[`CTRL_EXP_EN];
   wire seq_enable = exp_enable & s_int;
   wire [5:0] stretch_waits = waits_for(units, fast) + {5'h00, s_one_more};

   // T-state tick from the local clock
   reg [6:0] div;
   wire tick = (div == 7'h00);
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div <= 7'h00;
      end else if (tick) begin
         div <= fast ? DIV_FAST : DIV_SLOW;
      end else begin
         div <= div - 7'h01;
      end
   end

   // Opcode fetch tracking: each fetch is judged once
   wire fetch = s_m1 & s_rd & ~s_iorq;
   reg fetch_seen;
   wire fetch_new = fetch & ~fetch_seen;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fetch_seen <= 1'b0;
      end else begin
         fetch_seen <= fetch;
      end
   end

   // Wait state sequencer
   reg [4:0] state;
   reg [4:0] next_state;
   reg [5:0] wait_cnt;
   reg [5:0] next_wait_cnt;
   reg next_wait;
   always @* begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_wait = 1'b0;
      events = {`EV_WIDTH{1'b0}};
      case (state)
         ST_IDLE: begin
            if (fetch_new & seq_enable & (s_data == `OPC_PREFIX)) begin
               next_state = ST_PREFIX;
               next_wait_cnt = `PREFIX_WAITS;
               next_wait = 1'b1;
               events[`EV_PREFIX] = 1'b1;
            end
         end
         ST_PREFIX: begin
            next_wait = 1'b1;
            if (tick) begin
               next_wait_cnt = wait_cnt - 6'h01;
               if (wait_cnt == 6'h01) begin
                  next_state = ST_AWAIT;
                  next_wait = 1'b0;
               end
            end
         end
         ST_AWAIT: begin
            if (!fetch) begin
               next_state = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (fetch_new) begin
               if (s_data == `OPC_RETURN && stretch_waits != 6'h00) begin
                  next_state = ST_STRETCH;
                  next_wait_cnt = stretch_waits;
                  next_wait = 1'b1;
                  events[`EV_RETURN] = 1'b1;
               end else begin
                  next_state = ST_IDLE;
                  events[`EV_OTHER] = 1'b1;
               end
            end
         end
         ST_STRETCH: begin
            next_wait = 1'b1;
            if (tick) begin
               next_wait_cnt = wait_cnt - 6'h01;
               if (wait_cnt == 6'h01) begin
                  next_state = ST_IDLE;
                  next_wait = 1'b0;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (!exp_enable) begin
         next_state = ST_IDLE;
         next_wait = 1'b0;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         wait_cnt <= 6'h00;
         o_bus_wait_n <= 1'b1;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         // Wait is only ever requested inside a fetch, so plain code never sees it
         o_bus_wait_n <= ~next_wait;
      end
   end

   // Register port; a hardware event wins over a same-cycle clear
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= `CTRL_RESET;
         status <= {`EV_WIDTH{1'b0}};
         mask <= {`EV_WIDTH{1'b0}};
         o_reg_rdata <= 8'h00;
      end else begin
         if (i_reg_wr && i_reg_addr == `REG_CTRL) begin
            ctrl <= {6'h00, i_reg_wdata[1:0]};
         end
         if (i_reg_wr && i_reg_addr == `REG_MASK) begin
            mask <= i_reg_wdata[`EV_WIDTH-1:0];
         end
         if (i_reg_wr && i_reg_addr == `REG_STATUS) begin
            status <= (status & ~i_reg_wdata[`EV_WIDTH-1:0]) | events;
         end else begin
            status <= status | events;
         end
         if (i_reg_rd) begin
            case (i_reg_addr)
               `REG_CTRL: o_reg_rdata <= ctrl;
               `REG_STATUS: o_reg_rdata <= {5'h00, status};
               `REG_MASK: o_reg_rdata <= {5'h00, mask};
               `REG_INFO: o_reg_rdata <= {~o_bus_wait_n, exp_enable, board_addr};
               default: o_reg_rdata <= 8'h00;
            endcase
         end else begin
            o_reg_rdata <= 8'h00;
         end
      end
   end

   assign o_irq = |(status & mask);

endmodule // interrupt_expander_wait_logic

//--- testbench/irq_expander_sva.sv
// Assertion checker for the expander bus glue
`timescale 1ns/1ps
module irq_expander_sva (
   input wire i_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [7:0] i_data,
   input wire i_iorq_n,
   input wire i_rd_n,
   input wire i_m1_n,
   input wire i_int_active,
   input wire [5:0] i_board_address_header,
   input wire i_expansion_disable_jumper,
   input wire [3:0] i_count_trigger_input,
   input wire i_reg_rd,
   input wire o_bus_wait_n,
   input wire o_xcvr_drive_out,
   input wire o_counter_timer_chip_enable,
   input wire [1:0] o_channel_select,
   input wire [3:0] o_count_trigger,
   input wire [7:0] o_reg_rdata
);
   logic [2:0] age;
   logic [11:0] wlen;
   wire hit = i_addr[7:2] == ~i_board_address_header;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Synchronisers show reset values for three cycles, so pin checks wait
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         age <= 3'h0;
         wlen <= 12'h000;
      end else begin
         age <= (age == 3'h4) ? age : age + 3'h1;
         wlen <= o_bus_wait_n ? 12'h000 : wlen + 12'h001;
      end
   end
   chan_sel_a: assert property (age == 3'h4 |-> o_channel_select == $past(i_addr[1:0], 3))
      else $error("channel select");
   timer_en_a: assert property (age == 3'h4 |-> o_counter_timer_chip_enable == $past(!i_iorq_n && hit, 3))
      else $error("timer enable");
   xcvr_dir_a: assert property (age == 3'h4 |-> o_xcvr_drive_out ==
      $past(!i_iorq_n && (!i_m1_n || (!i_rd_n && hit)), 2)) else $error("transceiver direction");
   trig_copy_a: assert property (age == 3'h4 |-> o_count_trigger == $past(i_count_trigger_input, 3))
      else $error("trigger copy");
   no_wait_a: assert property (i_expansion_disable_jumper [*4] |-> o_bus_wait_n)
      else $error("wait while disabled");
   wait_cause_a: assert property ($fell(o_bus_wait_n) |-> $past(i_int_active && !i_m1_n, 3))
      else $error("wait without cause");
   prefix_wait_a: assert property ($fell(i_m1_n) && !i_rd_n && i_iorq_n && i_data == 8'hed && i_int_active
      && !i_expansion_disable_jumper ##1 !i_m1_n |-> ##[1:3] !o_bus_wait_n) else $error("prefix wait");
   wait_len_a: assert property (wlen < 12'h960)
      else $error("wait too long");
   rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("read data idle");
   cover property ($fell(o_bus_wait_n));
   cover property (wlen == 12'h400);
   cover property (o_counter_timer_chip_enable && o_xcvr_drive_out);
endmodule // irq_expander_sva
bind interrupt_expander_wait_logic irq_expander_sva u_irq_expander_sva (.*);

//--- testbench/host_bus_model.sv
// Host processor model on the backplane bus
`timescale 1ns/1ps
module host_bus_model (
   // Clock and wait
   input wire i_clk,
   input wire i_bus_wait_n,
   // Bus pins
   output logic [7:0] o_addr = 8'hff,
   output logic [7:0] o_data = 8'h00,
   output logic o_iorq_n = 1'b1,
   output logic o_rd_n = 1'b1,
   output logic o_m1_n = 1'b1
);
   // I/O read or vector read; a released address shows its inverse
   task io(input logic [7:0] a, input logic iq, input logic m);
      @(posedge i_clk);
      o_addr <= iq ? a : ~o_addr;
      o_iorq_n <= ~iq;
      o_rd_n <= ~iq;
      o_m1_n <= ~m;
   endtask
   // Inserts no waits of its own, so the one-more jumper may stay fitted
   task fetch(input logic [7:0] op, output int w);
      int i;
      w = 0;
      i = 0;
      repeat (3) @(posedge i_clk);
      o_m1_n <= 1'b0;
      o_rd_n <= 1'b0;
      o_data <= op;
      while ((i < 6 || i_bus_wait_n !== 1'b1) && i < 4000) begin
         @(negedge i_clk);
         i++;
         w += (i_bus_wait_n === 1'b0);
      end
      @(posedge i_clk);
      o_m1_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_data <= ~op;
   endtask
endmodule // host_bus_model

//--- testbench/tb_top.sv
// Self-checking bench for the expander bus glue
`timescale 1ns/1ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic int_act = 1'b0;
   logic [5:0] hdr = 6'h2a;
   logic [1:0] units = 2'h3;
   logic one_more = 1'b0;
   logic dis = 1'b0;
   logic [3:0] trig = 4'h0;
   logic [2:0] zc = 3'h0;
   logic [1:0] ra = 2'h0;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   wire [7:0] addr, data, rdata;
   wire iorq_n, rd_n, m1_n, wait_n, drv, en, irq;
   wire [1:0] chan;
   wire [3:0] trig_out;
   wire [2:0] zc_out;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int w;
   int n_tab [6] = '{10, 17, 26, 12, 20, 28};
   logic [1:0] u_tab [3] = '{2'h3, 2'h2, 2'h0};
   interrupt_expander_wait_logic u_interrupt_expander_wait_logic (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
      .i_data(data), .i_iorq_n(iorq_n), .i_rd_n(rd_n), .i_m1_n(m1_n), .i_int_active(int_act),
      .i_board_address_header(hdr), .i_unit_count_header(units), .i_one_more_jumper(one_more),
      .i_expansion_disable_jumper(dis), .i_count_trigger_input(trig), .i_zero_count_chip(zc),
      .o_bus_wait_n(wait_n), .o_xcvr_drive_out(drv), .o_counter_timer_chip_enable(en), .o_channel_select(chan),
      .o_count_trigger(trig_out), .o_zero_count_output(zc_out), .i_reg_addr(ra), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
   host_bus_model u_host_bus_model (.i_clk(i_clk), .i_bus_wait_n(wait_n), .o_addr(addr), .o_data(data),
      .o_iorq_n(iorq_n), .o_rd_n(rd_n), .o_m1_n(m1_n));
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task chk_n(input string name, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         errors++;
         $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   task reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task reg_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      @(negedge i_clk);
      chk("register", exp, rdata);
   endtask
   // Holds a bus cycle long enough to pass the pin synchronisers
   task probe(input logic [7:0] a, input logic m, input logic exp_en, input logic exp_drv);
      u_host_bus_model.io(a, 1'b1, m);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk("timer enable", exp_en, en);
      chk("drive out", exp_drv, drv);
      chk("channel", a[1:0], chan);
      u_host_bus_model.io(a, 1'b0, 1'b0);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk("drive idle", 1'b0, drv);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      reg_chk(2'h0, 8'h01);
      reg_chk(2'h2, 8'h00);
      reg_chk(2'h3, {2'b01, ~hdr});
      for (int c = 0; c < 4; c++) begin
         trig <= 4'h1 << c;
         zc <= 3'h7 >> c;
         probe({~hdr, c[1:0]}, 1'b0, 1'b1, 1'b1);
         chk("trigger", 4'h1 << c, trig_out);
         chk("zero count", 3'h7 >> c, zc_out);
      end
      probe({~hdr ^ 6'h20, 2'h1}, 1'b0, 1'b0, 1'b0);
      probe({~hdr ^ 6'h01, 2'h2}, 1'b1, 1'b0, 1'b1);
      int_act <= 1'b1;
      reg_wr(2'h2, 8'h02);
      u_host_bus_model.fetch(8'hed, w);
      chk_n("prefix wait", 1, 81, w);
      u_host_bus_model.fetch(8'h4e, w);
      chk_n("other byte wait", 0, 0, w);
      reg_chk(2'h1, 8'h05);
      chk("masked irq", 1'b0, irq);
      reg_wr(2'h1, 8'h07);
      reg_chk(2'h1, 8'h00);
      for (int k = 0; k < 6; k++) begin
         reg_wr(2'h0, k < 3 ? 8'h01 : 8'h03);
         units <= u_tab[k % 3];
         one_more <= (k == 0);
         u_host_bus_model.fetch(8'hed, w);
         u_host_bus_model.fetch(8'h4d, w);
         w = w - (k == 0) * (k < 3 ? 80 : 50);
         chk_n("stretch", (n_tab[k] - 1) * (k < 3 ? 80 : 50), n_tab[k] * (k < 3 ? 80 : 50) + 2, w);
         chk("irq", 1'b1, irq);
         reg_wr(2'h1, 8'h03);
         @(negedge i_clk);
         chk("irq clear", 1'b0, irq);
      end
      dis <= 1'b1;
      u_host_bus_model.fetch(8'hed, w);
      chk_n("disabled prefix", 0, 0, w);
      u_host_bus_model.fetch(8'h4d, w);
      chk_n("disabled stretch", 0, 0, w);
      dis <= 1'b0;
      int_act <= 1'b0;
      u_host_bus_model.fetch(8'hed, w);
      chk_n("idle prefix", 0, 0, w);
      wrap_up();
   end
endmodule // tb_top
